//--- design/block_frame_counter.sv
// Frame counter that marks the end of each block of audio frames.
// Assumes frame start is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module block_frame_counter #(
	parameter int LEN_W = sup_pkg::DATA_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic frame_start_in,
	input wire logic [LEN_W-1:0] length_in,
	output logic block_out
);
	logic [LEN_W-1:0] frames;
	logic [LEN_W:0] next_frames;

	assign next_frames = {1'b0, frames} + (LEN_W+1)'(1);

	// ==========================================================
	// Counting
	// A length of zero is never reached, so no block ever ends.
	always_ff @(posedge clk_in) begin
		if (rst_in || !enable_in) begin
			frames <= '0;
			block_out <= 1'b0;
		end else if (frame_start_in) begin
			if (next_frames == {1'b0, length_in}) begin // R13
				frames <= '0;
				block_out <= 1'b1;
			end else begin
				frames <= next_frames[LEN_W-1:0]; // R12
				block_out <= 1'b0;
			end
		end else begin
			block_out <= 1'b0;
		end
	end
endmodule : block_frame_counter

//--- design/dsp_supervisor.sv
// Watchdog, error code capture, error program count and block interrupt logic.
// Assumes all inputs come from core logic on clk_in; no synchronisers needed.
// How it works
// R1 - Read-only error code bits, zero at reset
// R2 - Only first error latched until panic clear
// R3 - Software error stores execute stage program count
// R4 - Watchdog starts at maximum, counts down by one
// R5 - Program start reloads watchdog with maximum count
// R6 - Counter reaching zero raises watchdog error
// R7 - Maximum count is 13 bits, reset zero
// R8 - Timeout equals maximum count times prescale factor
// R9 - Prescale code selects 64 doubling to 131072 cycles
// R10 - Software sets maximum slightly above frame instructions
// R11 - Enable bit zero gates block interrupts
// R12 - Block counter increments per frame start
// R13 - Reaching block length interrupts and restarts counter
// R14 - Block length register is 16 bits wide
// R15 - One downward step per elapsed prescale interval
`timescale 1ns/1ps
module dsp_supervisor #(
	parameter int STEP_BASE_CYCLES = sup_pkg::STEP_BASE_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire sup_pkg::reg_req_t reg_req_in,
	output logic [sup_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic prog_start_in,
	input wire logic frame_start_in,
	input wire sup_pkg::error_code_t fault_in,
	input wire logic [15:0] exec_pc_in,
	input wire logic panic_clear_in,
	output logic watchdog_error_out,
	output logic block_irq_out,
	output logic irq_out
);
	logic [15:0] err_pc;
	logic [sup_pkg::WD_START_W-1:0] wd_start;
	logic [sup_pkg::DIV_CODE_W-1:0] wd_div;
	logic blk_en;
	logic [15:0] blk_len;
	sup_pkg::error_code_t err_code;
	sup_pkg::error_code_t new_fault;
	logic [sup_pkg::IRQ_W-1:0] irq_status;
	logic [sup_pkg::IRQ_W-1:0] irq_mask;
	logic [sup_pkg::IRQ_W-1:0] irq_events;
	logic [sup_pkg::WD_START_W-1:0] wd_count;
	logic wd_armed;
	logic wd_step;
	logic wd_fire;
	logic capture;
	logic wr_hit;

	assign wr_hit = reg_req_in.wr;

	// ==========================================================
	// Software-written controls
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wd_start <= sup_pkg::REG_RESET[sup_pkg::WD_START_W-1:0];
			wd_div <= sup_pkg::REG_RESET[sup_pkg::DIV_CODE_W-1:0];
			blk_en <= 1'b0;
			blk_len <= sup_pkg::REG_RESET;
			irq_mask <= '0;
		end else if (wr_hit) begin
			case (reg_req_in.addr)
				sup_pkg::ADDR_WD_START: begin
					wd_start <= reg_req_in.wdata[sup_pkg::WD_START_W-1:0]; // R7
				end
				sup_pkg::ADDR_WD_DIV: begin
					wd_div <= reg_req_in.wdata[sup_pkg::DIV_CODE_W-1:0]; // R9
				end
				sup_pkg::ADDR_BLK_EN: begin
					blk_en <= reg_req_in.wdata[sup_pkg::BLK_EN_BIT]; // R11
				end
				sup_pkg::ADDR_BLK_LEN: begin
					blk_len <= reg_req_in.wdata; // R14
				end
				sup_pkg::ADDR_IRQ_MASK: begin
					irq_mask <= reg_req_in.wdata[sup_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Error program count
	// A capture in the same cycle as a software write wins, so no error is lost.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			err_pc <= sup_pkg::REG_RESET;
		end else if (fault_in.soft_fault) begin
			err_pc <= exec_pc_in; // R3
		end else if (wr_hit && reg_req_in.addr == sup_pkg::ADDR_ERR_PC) begin
			err_pc <= reg_req_in.wdata;
		end
	end

	// ==========================================================
	// Watchdog
	step_prescaler #(
		.BASE_CYCLES(STEP_BASE_CYCLES),
		.CNT_W(sup_pkg::STEP_CNT_W)
	) u_prescaler (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.restart_in(prog_start_in),
		.code_in(wd_div),
		.step_out(wd_step)
	);

	assign wd_fire = wd_armed && wd_step && !prog_start_in
		&& wd_count == sup_pkg::WD_START_W'(1);

	// A zero maximum leaves the watchdog disarmed rather than firing at once.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wd_count <= '0;
			wd_armed <= 1'b0;
		end else if (prog_start_in) begin
			wd_count <= wd_start; // R5
			wd_armed <= (wd_start != '0);
		end else if (wd_armed && wd_step && wd_count != '0) begin
			wd_count <= wd_count - sup_pkg::WD_START_W'(1); // R4 R8 R15
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || prog_start_in) begin
			watchdog_error_out <= 1'b0;
		end else if (wd_fire) begin
			watchdog_error_out <= 1'b1; // R6
		end
	end

	// ==========================================================
	// Error code capture
	always_comb begin
		new_fault = fault_in;
		new_fault.watchdog_fault = wd_fire; // R6
	end

	assign capture = (new_fault != '0) && (err_code == '0 || panic_clear_in);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			err_code <= '0; // R1
		end else if (capture) begin
			err_code <= new_fault; // R1 R2
		end else if (panic_clear_in) begin
			err_code <= '0; // R2
		end
	end

	// ==========================================================
	// Block interrupt counter
	block_frame_counter #(
		.LEN_W(sup_pkg::DATA_W)
	) u_block (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.enable_in(blk_en),
		.frame_start_in(frame_start_in),
		.length_in(blk_len),
		.block_out(block_irq_out)
	);

	// ==========================================================
	// Interrupt status, mask and output
	always_comb begin
		irq_events = '0;
		irq_events[sup_pkg::IRQ_BLOCK] = block_irq_out;
		irq_events[sup_pkg::IRQ_WDOG] = wd_fire;
		irq_events[sup_pkg::IRQ_FAULT] = capture;
	end

	// Set wins over the write-one clear of the same bit.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_status <= '0;
		end else if (wr_hit && reg_req_in.addr == sup_pkg::ADDR_IRQ_STATUS) begin
			irq_status <= (irq_status & ~reg_req_in.wdata[sup_pkg::IRQ_W-1:0]) | irq_events;
		end else begin
			irq_status <= irq_status | irq_events;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_status & irq_mask);
		end
	end

	// ==========================================================
	// Read port
	// Data stand for one cycle only; unmapped addresses read as zero.
	always_ff @(posedge clk_in) begin
		if (rst_in || !reg_req_in.rd) begin
			reg_rdata_out <= '0;
		end else begin
			case (reg_req_in.addr)
				sup_pkg::ADDR_ERR_PC: reg_rdata_out <= err_pc;
				sup_pkg::ADDR_WD_START: reg_rdata_out <= 16'(wd_start); // R7
				sup_pkg::ADDR_WD_DIV: reg_rdata_out <= 16'(wd_div);
				sup_pkg::ADDR_BLK_EN: reg_rdata_out <= 16'(blk_en);
				sup_pkg::ADDR_BLK_LEN: reg_rdata_out <= blk_len;
				sup_pkg::ADDR_ERR_CODE: reg_rdata_out <= err_code; // R1
				sup_pkg::ADDR_IRQ_STATUS: reg_rdata_out <= 16'(irq_status);
				sup_pkg::ADDR_IRQ_MASK: reg_rdata_out <= 16'(irq_mask);
				default: reg_rdata_out <= '0;
			endcase
		end
	end

	// ==========================================================
	// Checks
	logic [sup_pkg::STEP_CNT_W-1:0] step_gap;
	logic [sup_pkg::STEP_CNT_W-1:0] step_last;
	logic [sup_pkg::DIV_CODE_W-1:0] div_eff;
	logic gap_valid;

	assign div_eff = (wd_div > sup_pkg::DIV_CODE_MAX) ? sup_pkg::DIV_CODE_MAX : wd_div;
	assign step_last = (sup_pkg::STEP_CNT_W'(STEP_BASE_CYCLES) << div_eff)
		- sup_pkg::STEP_CNT_W'(1);

	// A new step period makes the gap measured under the old one meaningless.
	always_ff @(posedge clk_in) begin
		if (rst_in || prog_start_in
			|| (wr_hit && reg_req_in.addr == sup_pkg::ADDR_WD_DIV)) begin
			step_gap <= '0;
			gap_valid <= 1'b0;
		end else if (wd_step) begin
			step_gap <= '0;
			gap_valid <= 1'b1;
		end else begin
			step_gap <= step_gap + sup_pkg::STEP_CNT_W'(1);
		end
	end

	a_code_first_error: assert property (@(posedge clk_in) disable iff (rst_in) // R1
		err_code == '0 && new_fault != '0 |=> err_code == $past(new_fault))
		else $error("first error not captured");

	a_code_holds_first: assert property (@(posedge clk_in) disable iff (rst_in) // R2
		err_code != '0 && !panic_clear_in |=> err_code == $past(err_code))
		else $error("error code changed without clear");

	a_pc_capture: assert property (@(posedge clk_in) disable iff (rst_in) // R3
		fault_in.soft_fault |=> err_pc == $past(exec_pc_in))
		else $error("program count not captured");

	a_wd_reload: assert property (@(posedge clk_in) disable iff (rst_in) // R5
		prog_start_in |=> wd_count == $past(wd_start) && !watchdog_error_out)
		else $error("watchdog not reloaded");

	a_wd_step_down: assert property (@(posedge clk_in) disable iff (rst_in) // R4
		wd_armed && wd_step && wd_count != '0 && !prog_start_in
		|=> wd_count == $past(wd_count) - sup_pkg::WD_START_W'(1))
		else $error("watchdog did not step down by one");

	a_wd_holds: assert property (@(posedge clk_in) disable iff (rst_in) // R15
		!wd_step && !prog_start_in |=> $stable(wd_count))
		else $error("watchdog moved between steps");

	a_step_period: assert property (@(posedge clk_in) disable iff (rst_in) // R8
		wd_step && gap_valid && !prog_start_in |-> step_gap == step_last)
		else $error("prescale interval wrong");

	a_wd_error_raise: assert property (@(posedge clk_in) disable iff (rst_in) // R6
		wd_fire |=> watchdog_error_out && wd_count == '0)
		else $error("watchdog error not raised at zero");

	a_start_width: assert property (@(posedge clk_in) disable iff (rst_in) // R7
		reg_req_in.rd && reg_req_in.addr == sup_pkg::ADDR_WD_START
		|=> reg_rdata_out[15:sup_pkg::WD_START_W] == '0)
		else $error("reserved maximum count bits not zero");

	a_block_gated: assert property (@(posedge clk_in) disable iff (rst_in) // R11
		!blk_en |=> !block_irq_out)
		else $error("block interrupt while disabled");

	c_wd_fires: cover property (@(posedge clk_in) disable iff (rst_in) wd_fire);
	c_block_ends: cover property (@(posedge clk_in) disable iff (rst_in) block_irq_out);
	c_first_capture: cover property (@(posedge clk_in) disable iff (rst_in)
		capture ##1 (new_fault != '0));
	c_irq_raised: cover property (@(posedge clk_in) disable iff (rst_in) $rose(irq_out));

endmodule : dsp_supervisor

//--- design/step_prescaler.sv
// Step generator for the watchdog: one pulse per selected number of cycles.
// Assumes restart and code come from logic on the same clock.
`timescale 1ns/1ps
module step_prescaler #(
	parameter int BASE_CYCLES = sup_pkg::STEP_BASE_CYCLES,
	parameter int CNT_W = sup_pkg::STEP_CNT_W
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic restart_in,
	input wire logic [sup_pkg::DIV_CODE_W-1:0] code_in,
	output logic step_out
);
	logic [CNT_W-1:0] cycles;
	logic [CNT_W-1:0] last;
	logic [sup_pkg::DIV_CODE_W-1:0] code;

	// ==========================================================
	// Period select
	// Codes above the largest documented one act as the largest.
	always_comb begin
		code = (code_in > sup_pkg::DIV_CODE_MAX) ? sup_pkg::DIV_CODE_MAX : code_in;
		last = (CNT_W'(BASE_CYCLES) << code) - CNT_W'(1); // R9
	end

	// ==========================================================
	// Cycle counter
	always_ff @(posedge clk_in) begin
		if (rst_in || restart_in) begin
			cycles <= '0;
			step_out <= 1'b0;
		end else if (cycles >= last) begin
			cycles <= '0;
			step_out <= 1'b1; // R15
		end else begin
			cycles <= cycles + CNT_W'(1);
			step_out <= 1'b0;
		end
	end
endmodule : step_prescaler

//--- shared/sup_pkg.sv
// Constants, register map and carrier types of the DSP supervision block.
// Assumes a 16-bit register port and one core clock shared by all users.
package sup_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam logic [15:0] ADDR_ERR_PC = 16'hf432;
	localparam logic [15:0] ADDR_WD_START = 16'hf443;
	localparam logic [15:0] ADDR_WD_DIV = 16'hf444;
	localparam logic [15:0] ADDR_BLK_EN = 16'hf450;
	localparam logic [15:0] ADDR_BLK_LEN = 16'hf451;
	localparam logic [15:0] ADDR_ERR_CODE = 16'hf470;
	localparam logic [15:0] ADDR_IRQ_STATUS = 16'hf471;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hf472;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// ==========================================================
	// Field layout
	localparam int WD_START_W = 13;
	localparam int DIV_CODE_W = 4;
	localparam logic [3:0] DIV_CODE_MAX = 4'hb;
	localparam int STEP_BASE_CYCLES = 64;
	localparam int STEP_CNT_W = 18;
	localparam int BLK_EN_BIT = 0;
	localparam int IRQ_W = 3;
	localparam int IRQ_BLOCK = 0;
	localparam int IRQ_WDOG = 1;
	localparam int IRQ_FAULT = 2;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic soft_fault;
		logic loop_fault;
		logic stack_fault;
		logic watchdog_fault;
		logic dmem1_bank3_fault;
		logic dmem1_bank2_fault;
		logic dmem1_bank1_fault;
		logic dmem1_bank0_fault;
		logic dmem0_bank3_fault;
		logic dmem0_bank2_fault;
		logic dmem0_bank1_fault;
		logic dmem0_bank0_fault;
		logic progmem1_fault;
		logic progmem0_fault;
		logic rate_conv1_fault;
		logic rate_conv0_fault;
	} error_code_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : sup_pkg

//--- tb/testbench.sv
// Self-checking bench for the DSP supervision block, one task per scenario.
// Assumes sup_pkg and the design files are compiled first.
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Stimulus and observation
	// A small step base keeps the longest timeout well within the run budget.
	localparam int BASE = 4;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	sup_pkg::reg_req_t req = '0;
	logic [15:0] rdata;
	logic prog_start = 1'b0;
	logic frame_start = 1'b0;
	sup_pkg::error_code_t fault = '0;
	logic [15:0] exec_pc = 16'h0000;
	logic panic_clear = 1'b0;
	logic wd_err;
	logic blk_irq;
	logic irq;
	int fail_count = 0;
	int checks_done = 0;
	logic [15:0] got;

	always #5 clk_in = ~clk_in;

	dsp_supervisor #(.STEP_BASE_CYCLES(BASE)) i_dut (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.reg_req_in(req),
		.reg_rdata_out(rdata),
		.prog_start_in(prog_start),
		.frame_start_in(frame_start),
		.fault_in(fault),
		.exec_pc_in(exec_pc),
		.panic_clear_in(panic_clear),
		.watchdog_error_out(wd_err),
		.block_irq_out(blk_irq),
		.irq_out(irq)
	);

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, want, seen);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		req.wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rc(input string n, input logic [15:0] a, input logic [15:0] w);
		@(posedge clk_in);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		req.rd <= 1'b0;
		#1;
		check(n, rdata, w);
	endtask : rc

	task automatic pulse(input logic p, input logic fr, input logic [15:0] f, input logic c,
		input logic [15:0] pc);
		@(posedge clk_in);
		prog_start <= p;
		frame_start <= fr;
		fault <= f;
		panic_clear <= c;
		exec_pc <= pc;
		@(posedge clk_in);
		prog_start <= 1'b0;
		frame_start <= 1'b0;
		fault <= '0;
		panic_clear <= 1'b0;
		#1;
	endtask : pulse

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rc("error_program_count", sup_pkg::ADDR_ERR_PC, 16'h0000);
		rc("watchdog_start_value", sup_pkg::ADDR_WD_START, 16'h0000);
		rc("watchdog_step_divider", sup_pkg::ADDR_WD_DIV, 16'h0000);
		rc("block_irq_enable", sup_pkg::ADDR_BLK_EN, 16'h0000);
		rc("block_length_frames", sup_pkg::ADDR_BLK_LEN, 16'h0000);
		rc("error_source_code", sup_pkg::ADDR_ERR_CODE, 16'h0000);
		rc("unmapped read", 16'hf400, 16'h0000);
		#10;
		check("idle read data", rdata, 16'h0000);
		check("watchdog_error_out", wd_err, 1'b0);
	endtask : t_reset

	task automatic t_regs();
		wr(sup_pkg::ADDR_ERR_PC, 16'hffff);
		rc("error_program_count", sup_pkg::ADDR_ERR_PC, 16'hffff);
		wr(sup_pkg::ADDR_WD_START, 16'hffff);
		rc("watchdog_start_value", sup_pkg::ADDR_WD_START, 16'h1fff);
		wr(sup_pkg::ADDR_WD_DIV, 16'hffff);
		rc("watchdog_step_divider", sup_pkg::ADDR_WD_DIV, 16'h000f);
		wr(sup_pkg::ADDR_BLK_EN, 16'hffff);
		rc("block_irq_enable", sup_pkg::ADDR_BLK_EN, 16'h0001);
		wr(sup_pkg::ADDR_BLK_LEN, 16'hffff);
		rc("block_length_frames", sup_pkg::ADDR_BLK_LEN, 16'hffff);
		wr(sup_pkg::ADDR_ERR_CODE, 16'hffff);
		rc("error_source_code", sup_pkg::ADDR_ERR_CODE, 16'h0000);
		wr(16'hf400, 16'hffff);
		rc("unmapped read", 16'hf400, 16'h0000);
		wr(sup_pkg::ADDR_BLK_EN, 16'h0000);
		wr(sup_pkg::ADDR_ERR_PC, 16'h0000);
	endtask : t_regs

	task automatic t_codes();
		for (int i = 0; i < 12; i++) begin
			pulse(1'b0, 1'b0, 16'h0000, 1'b1, 16'h0000);
			pulse(1'b0, 1'b0, 16'h0001 << i, 1'b0, 16'h0000);
			rc("error_source_code", sup_pkg::ADDR_ERR_CODE, 16'h0001 << i);
		end
		pulse(1'b0, 1'b0, 16'h0080, 1'b0, 16'h0000);
		rc("error_source_code", sup_pkg::ADDR_ERR_CODE, 16'h0800);
		pulse(1'b0, 1'b0, 16'h0000, 1'b1, 16'h0000);
		pulse(1'b0, 1'b0, 16'h8000, 1'b0, 16'hbeef);
		rc("error_source_code", sup_pkg::ADDR_ERR_CODE, 16'h8000);
		rc("error_program_count", sup_pkg::ADDR_ERR_PC, 16'hbeef);
	endtask : t_codes

	task automatic t_block();
		wr(sup_pkg::ADDR_BLK_LEN, 16'h0003);
		wr(sup_pkg::ADDR_BLK_EN, 16'h0001);
		for (int k = 1; k <= 7; k++) begin
			pulse(1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
			check("block_irq_out", blk_irq, k % 3 == 0);
		end
		wr(sup_pkg::ADDR_BLK_EN, 16'h0000);
		for (int k = 1; k <= 3; k++) begin
			pulse(1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
			check("block_irq_out disabled", blk_irq, 1'b0);
		end
		wr(sup_pkg::ADDR_BLK_EN, 16'h0001);
		for (int k = 1; k <= 3; k++) begin
			pulse(1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
			check("block_irq_out restart", blk_irq, k == 3);
		end
		rc("irq status", sup_pkg::ADDR_IRQ_STATUS, 16'h0005);
	endtask : t_block

	task automatic t_irq();
		wr(sup_pkg::ADDR_IRQ_MASK, 16'h0000);
		wr(sup_pkg::ADDR_IRQ_STATUS, 16'h0007);
		pulse(1'b0, 1'b0, 16'h0001, 1'b1, 16'h0000);
		rc("irq status", sup_pkg::ADDR_IRQ_STATUS, 16'h0004);
		check("irq_out masked", irq, 1'b0);
		wr(sup_pkg::ADDR_IRQ_MASK, 16'h0004);
		repeat (2) @(posedge clk_in);
		#1;
		check("irq_out raised", irq, 1'b1);
		wr(sup_pkg::ADDR_IRQ_STATUS, 16'h0004);
		repeat (2) @(posedge clk_in);
		#1;
		check("irq_out cleared", irq, 1'b0);
		rc("irq status", sup_pkg::ADDR_IRQ_STATUS, 16'h0000);
		rc("irq mask", sup_pkg::ADDR_IRQ_MASK, 16'h0004);
	endtask : t_irq

	// Codes above the last one behave as the last one.
	task automatic t_wd(input logic [15:0] start, input logic [3:0] code, input int pre);
		int n;
		int c;
		int want;
		c = (code > sup_pkg::DIV_CODE_MAX) ? 11 : int'(code);
		want = int'(start) * (BASE << c) + 1;
		wr(sup_pkg::ADDR_WD_START, start);
		wr(sup_pkg::ADDR_WD_DIV, {12'h000, code});
		pulse(1'b0, 1'b0, 16'h0000, 1'b1, 16'h0000);
		if (pre > 0) begin
			pulse(1'b1, 1'b0, 16'h0000, 1'b0, 16'h0000);
			repeat (pre) @(posedge clk_in);
		end
		pulse(1'b1, 1'b0, 16'h0000, 1'b0, 16'h0000);
		check("watchdog_error_out after reload", wd_err, 1'b0);
		n = 0;
		while (wd_err !== 1'b1 && n < 40000) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check("watchdog timeout cycles", n, want);
		if (n >= 40000) begin
			conclude();
		end
		rc("error_source_code", sup_pkg::ADDR_ERR_CODE, 16'h1000);
		rc("irq status", sup_pkg::ADDR_IRQ_STATUS, 16'h0006);
		wr(sup_pkg::ADDR_IRQ_STATUS, 16'h0007);
	endtask : t_wd

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_regs();
		t_codes();
		t_block();
		t_irq();
		t_wd(16'h0002, 4'h0, 0);
		t_wd(16'h0002, 4'h0, 7);
		t_wd(16'h0003, 4'h1, 0);
		t_wd(16'h0001, 4'hb, 0);
		t_wd(16'h0001, 4'hf, 0);
		conclude();
	end
endmodule : testbench
